// ### hw/ccs_pkg.sv
// common command, status and preset block: shared constants and types
// assumes one 50 MHz clock and a synchronous command port upstream

package ccs_pkg;

  // ---------------------------------------------------------------------
  // command port geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ccs_cmd_s;

  // ---------------------------------------------------------------------
  // command and query addresses
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_CLEAR_STATUS  = 5'h00;
  localparam logic [ADDR_W-1:0] A_EVENT_ENABLE  = 5'h01;
  localparam logic [ADDR_W-1:0] A_EVENT_STATUS  = 5'h02;
  localparam logic [ADDR_W-1:0] A_INDIV_STATUS  = 5'h03;
  localparam logic [ADDR_W-1:0] A_OP_COMPLETE   = 5'h04;
  localparam logic [ADDR_W-1:0] A_OP_COMPLETE_Q = 5'h05;
  localparam logic [ADDR_W-1:0] A_OPTION_INDEX  = 5'h06;
  localparam logic [ADDR_W-1:0] A_OPTION_DATA   = 5'h07;
  localparam logic [ADDR_W-1:0] A_PPOLL_ENABLE  = 5'h08;
  localparam logic [ADDR_W-1:0] A_POWER_CLEAR   = 5'h09;
  localparam logic [ADDR_W-1:0] A_RECALL        = 5'h0A;
  localparam logic [ADDR_W-1:0] A_RESET         = 5'h0B;
  localparam logic [ADDR_W-1:0] A_SAVE          = 5'h0C;
  localparam logic [ADDR_W-1:0] A_SRQ_ENABLE    = 5'h0D;
  localparam logic [ADDR_W-1:0] A_STATUS_BYTE   = 5'h0E;
  localparam logic [ADDR_W-1:0] A_TRIGGER       = 5'h0F;
  localparam logic [ADDR_W-1:0] A_SELF_TEST     = 5'h10;
  localparam logic [ADDR_W-1:0] A_WAIT          = 5'h11;
  localparam logic [ADDR_W-1:0] A_DEVICE_PRESET = 5'h12;
  localparam logic [ADDR_W-1:0] A_PATH_PRESET   = 5'h13;
  localparam logic [ADDR_W-1:0] A_SYSTEM_PRESET = 5'h14;
  localparam logic [ADDR_W-1:0] A_FACTORY       = 5'h15;
  localparam logic [ADDR_W-1:0] A_OUTPUT_BUF    = 5'h16;
  localparam logic [ADDR_W-1:0] A_SET_PATH      = 5'h17;
  localparam logic [ADDR_W-1:0] A_SET_DEVICE    = 5'h18;
  localparam logic [ADDR_W-1:0] A_SET_SETUP     = 5'h19;
  localparam logic [ADDR_W-1:0] A_SET_PROTECT   = 5'h1A;

  // ---------------------------------------------------------------------
  // status byte and event register fields
  // ---------------------------------------------------------------------
  localparam int STB_ERRQ = 2;
  localparam int STB_QUES = 3;
  localparam int STB_MAV  = 4;
  localparam int STB_ESB  = 5;
  localparam int STB_MSS  = 6;
  localparam int STB_OPER = 7;
  localparam int ESR_OPC  = 0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] SRE_MASK  = 8'hBF;
  localparam logic       PSC_RST   = 1'b1;

  // ---------------------------------------------------------------------
  // instrument settings image
  // ---------------------------------------------------------------------
  localparam int NPATH   = 2;
  localparam int PATH_W  = 8;
  localparam int DEV_W   = 8;
  localparam int SETUP_W = 4;
  localparam int PROT_W  = 4;
  localparam int SLOTS   = 8;
  localparam int OPT_N   = 4;

  typedef struct packed {
    logic [NPATH-1:0][PATH_W-1:0] path;
    logic [DEV_W-1:0]             dev;
    logic [SETUP_W-1:0]           setup;
    logic [PROT_W-1:0]            prot;
  } ccs_settings_s;

  localparam int SET_W = $bits(ccs_settings_s);

  localparam logic [PATH_W-1:0]  PATH_DEF  = 8'h00;
  localparam logic [DEV_W-1:0]   DEV_DEF   = 8'h00;
  localparam logic [SETUP_W-1:0] SETUP_DEF = 4'h0;
  localparam logic [PROT_W-1:0]  PROT_DEF  = 4'h0;

endpackage : ccs_pkg

// ### hw/ccs_slot_mem.sv
// numbered intermediate settings memory, flip-flop storage
// assumes at most one write per cycle is requested by the owner

`timescale 1ns/100ps

module ccs_slot_mem #(
  parameter int SLOTS = ccs_pkg::SLOTS,
  parameter int W     = ccs_pkg::SET_W
) (
  input  wire logic                     mclk,   // system clock
  input  wire logic                     rstn,   // sync reset, active low
  input  wire logic                     we,     // store strobe
  input  wire logic [$clog2(SLOTS)-1:0] widx,   // slot to store
  input  wire logic [W-1:0]             wdata,  // image to store
  input  wire logic [$clog2(SLOTS)-1:0] ridx,   // slot to read
  output logic      [W-1:0]             rdata   // image held in slot
);

  // ---------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------
  logic [W-1:0] slot_reg [SLOTS];

  if (SLOTS < 2) begin : g_chk
    $error("ccs_slot_mem needs at least two slots");
  end

  for (genvar i = 0; i < SLOTS; i++) begin : g_slot
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        slot_reg[i] <= '0;
      end else if (we && widx == ($clog2(SLOTS))'(i)) begin
        slot_reg[i] <= wdata;
      end
    end
  end

  assign rdata = slot_reg[ridx];

endmodule : ccs_slot_mem

// ### hw/ccs_common.sv
// common command interpreter: status reporting, synchronisation, save and
// recall, self-test, trigger and the four preset scopes.
// assumes an upstream parser that maps each command onto one port access and
// that stops dispatching while hold is high.

`timescale 1ns/100ps

module ccs_common #(
  parameter int                 SLOTS    = ccs_pkg::SLOTS,
  parameter int                 OPT_N    = ccs_pkg::OPT_N,
  parameter logic [OPT_N*16-1:0] OPT_CODE = 64'h0004_0003_0002_0001  // arbitrary codes
) (
  input  wire logic                         mclk,           // 50 MHz clock
  input  wire logic                         rstn,           // sync reset, active low
  input  wire ccs_pkg::ccs_cmd_s            cmd,            // command port
  output ccs_pkg::ccs_settings_s            settings_o,     // active settings
  output logic [ccs_pkg::DATA_W-1:0]        rdata_o,        // read data, cycle after rd
  input  wire logic                         power_on,       // power-up event pulse
  input  wire logic                         exec_busy,      // earlier commands running
  input  wire logic                         settled,        // all signals settled
  input  wire logic [7:0]                   esr_set,        // other event sources
  input  wire logic                         err_avail,      // error queue not empty
  input  wire logic                         ques_sum,       // questionable summary
  input  wire logic                         oper_sum,       // operation summary
  input  wire logic [OPT_N-1:0]             opt_present,    // installed options
  input  wire logic                         file_load,      // file image into slot
  input  wire logic [$clog2(SLOTS)-1:0]     file_slot,      // slot for file image
  input  wire ccs_pkg::ccs_settings_s       file_image,     // image read from file
  input  wire logic                         tst_done,       // self-test finished
  input  wire logic [ccs_pkg::DATA_W-1:0]   tst_code,       // self-test result
  output logic                              tst_start_o,    // self-test start pulse
  output logic                              trig_o,         // manual trigger pulse
  output logic                              clr_event_o,    // clear ques/oper events
  output logic                              hold_o,         // stall later commands
  output logic                              srq_o,          // service request
  output logic                              ist_o,          // parallel poll bit
  output logic                              recall_o        // settings reloaded pulse
);

  localparam int SI_W = $clog2(SLOTS);
  localparam int OI_W = (OPT_N > 1) ? $clog2(OPT_N) : 1;

  if (SLOTS < 2 || SLOTS > 256 || OPT_N < 1 || OPT_N > 256) begin : g_chk
    $error("ccs_common: slot or option count out of range");
  end

  // ---------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------
  function automatic logic hit(input logic [ccs_pkg::ADDR_W-1:0] a,
                               input logic [ccs_pkg::ADDR_W-1:0] want);
    hit = (a == want);
  endfunction : hit

  wire w_cls   = cmd.wr && hit(cmd.addr, ccs_pkg::A_CLEAR_STATUS);
  wire w_ese   = cmd.wr && hit(cmd.addr, ccs_pkg::A_EVENT_ENABLE);
  wire r_esr   = cmd.rd && hit(cmd.addr, ccs_pkg::A_EVENT_STATUS);
  wire w_opc   = cmd.wr && hit(cmd.addr, ccs_pkg::A_OP_COMPLETE);
  wire w_opcq  = cmd.wr && hit(cmd.addr, ccs_pkg::A_OP_COMPLETE_Q);
  wire w_oidx  = cmd.wr && hit(cmd.addr, ccs_pkg::A_OPTION_INDEX);
  wire w_pre   = cmd.wr && hit(cmd.addr, ccs_pkg::A_PPOLL_ENABLE);
  wire w_psc   = cmd.wr && hit(cmd.addr, ccs_pkg::A_POWER_CLEAR);
  wire w_rcl   = cmd.wr && hit(cmd.addr, ccs_pkg::A_RECALL);
  wire w_sav   = cmd.wr && hit(cmd.addr, ccs_pkg::A_SAVE);
  wire w_sre   = cmd.wr && hit(cmd.addr, ccs_pkg::A_SRQ_ENABLE);
  wire w_trg   = cmd.wr && hit(cmd.addr, ccs_pkg::A_TRIGGER);
  wire w_tst   = cmd.wr && hit(cmd.addr, ccs_pkg::A_SELF_TEST);
  wire w_wai   = cmd.wr && hit(cmd.addr, ccs_pkg::A_WAIT);
  wire w_devp  = cmd.wr && hit(cmd.addr, ccs_pkg::A_DEVICE_PRESET);
  wire w_pathp = cmd.wr && hit(cmd.addr, ccs_pkg::A_PATH_PRESET);
  wire w_rst   = cmd.wr && (hit(cmd.addr, ccs_pkg::A_RESET) || hit(cmd.addr, ccs_pkg::A_SYSTEM_PRESET));
  wire w_fact  = cmd.wr && hit(cmd.addr, ccs_pkg::A_FACTORY);
  wire r_obuf  = cmd.rd && hit(cmd.addr, ccs_pkg::A_OUTPUT_BUF);
  wire w_spath = cmd.wr && hit(cmd.addr, ccs_pkg::A_SET_PATH);
  wire w_sdev  = cmd.wr && hit(cmd.addr, ccs_pkg::A_SET_DEVICE);
  wire w_ssup  = cmd.wr && hit(cmd.addr, ccs_pkg::A_SET_SETUP);
  wire w_sprot = cmd.wr && hit(cmd.addr, ccs_pkg::A_SET_PROTECT);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    CCS_IDLE = 3'b001,
    CCS_TEST = 3'b010,
    CCS_WAIT = 3'b100
  } ccs_state_e;

  ccs_state_e                  state_reg, state_next;
  logic [7:0]                  ese_reg, esr_reg, pre_reg, sre_reg;
  logic                        psc_reg;
  logic                        opc_arm_reg, opcq_arm_reg;
  logic [ccs_pkg::DATA_W-1:0]  obuf_reg;
  logic                        obuf_vld_reg;
  logic [OI_W-1:0]             oidx_reg;
  ccs_pkg::ccs_settings_s      set_reg, set_next;
  logic [ccs_pkg::DATA_W-1:0]  rdata_next;
  ccs_pkg::ccs_settings_s      slot_rdata;

  // ---------------------------------------------------------------------
  // completion and status byte
  // ---------------------------------------------------------------------
  // own self-test counts as an earlier command still running
  wire all_done = !exec_busy && settled && (state_reg != CCS_TEST);
  wire opc_fire  = opc_arm_reg && all_done;
  wire opcq_fire = opcq_arm_reg && all_done;
  wire tst_fire  = (state_reg == CCS_TEST) && tst_done;

  wire       esb = |(esr_reg & ese_reg);
  wire [7:0] stb_base = {oper_sum, 1'b0, esb, obuf_vld_reg, ques_sum, err_avail, 2'b00};
  wire       rqs = |(stb_base & sre_reg & ccs_pkg::SRE_MASK);
  wire [7:0] stb = stb_base | ({7'h00, rqs} << ccs_pkg::STB_MSS);
  // ist summarises the status byte through the parallel poll enable
  wire       ist = |(stb & pre_reg);

  // ---------------------------------------------------------------------
  // event status register: a new event wins over the clearing read
  // ---------------------------------------------------------------------
  wire [7:0] esr_hw  = esr_set | ({7'h00, opc_fire} << ccs_pkg::ESR_OPC);
  wire [7:0] esr_kep = (r_esr || w_cls) ? ccs_pkg::BYTE_ZERO : esr_reg;
  wire [7:0] esr_nx  = esr_kep | esr_hw;

  // ---------------------------------------------------------------------
  // enable registers and power-on clear
  // ---------------------------------------------------------------------
  wire pwr_clr = power_on && psc_reg;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ese_reg <= ccs_pkg::BYTE_ZERO;
      sre_reg <= ccs_pkg::BYTE_ZERO;
      pre_reg <= ccs_pkg::BYTE_ZERO;
      psc_reg <= ccs_pkg::PSC_RST;
    end else begin
      if (pwr_clr) begin
        ese_reg <= ccs_pkg::BYTE_ZERO;
        sre_reg <= ccs_pkg::BYTE_ZERO;
        pre_reg <= ccs_pkg::BYTE_ZERO;
      end else begin
        if (w_ese) ese_reg <= cmd.wdata[7:0];
        if (w_sre) sre_reg <= cmd.wdata[7:0] & ccs_pkg::SRE_MASK;
        if (w_pre) pre_reg <= cmd.wdata[7:0];
      end
      if (w_psc) psc_reg <= cmd.wdata[0];
    end
  end

  // ---------------------------------------------------------------------
  // event register, synchronisation arms and output buffer
  // ---------------------------------------------------------------------
  // a query result landing in the same cycle as a drain or clear survives
  wire                       obuf_load = opcq_fire || tst_fire;
  wire [ccs_pkg::DATA_W-1:0] obuf_val  = tst_fire ? tst_code : {{(ccs_pkg::DATA_W-1){1'b0}}, 1'b1};

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      esr_reg      <= ccs_pkg::BYTE_ZERO;
      opc_arm_reg  <= 1'b0;
      opcq_arm_reg <= 1'b0;
      obuf_reg     <= '0;
      obuf_vld_reg <= 1'b0;
    end else begin
      esr_reg      <= esr_nx;
      opc_arm_reg  <= w_opc || (opc_arm_reg && !opc_fire && !w_cls);
      opcq_arm_reg <= w_opcq || (opcq_arm_reg && !opcq_fire && !w_cls);
      if (obuf_load) begin
        obuf_reg     <= obuf_val;
        obuf_vld_reg <= 1'b1;
      end else if (w_cls || r_obuf) begin
        obuf_reg     <= '0;
        obuf_vld_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // self-test and wait sequencing
  // ---------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CCS_IDLE: begin
        if (w_tst) state_next = CCS_TEST;
        else if (w_wai) state_next = CCS_WAIT;
      end
      CCS_TEST: begin
        if (tst_done) state_next = CCS_IDLE;
      end
      CCS_WAIT: begin
        if (all_done) state_next = CCS_IDLE;
      end
      default: state_next = CCS_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) state_reg <= CCS_IDLE;
    else state_reg <= state_next;
  end

  // ---------------------------------------------------------------------
  // intermediate memory
  // ---------------------------------------------------------------------
  wire [SI_W-1:0] arg_slot = cmd.wdata[SI_W-1:0];
  // a file image and a save in one cycle: the command wins, the file is lost
  wire            slot_we  = w_sav || file_load;
  wire [SI_W-1:0] slot_wi  = w_sav ? arg_slot : file_slot;
  wire ccs_pkg::ccs_settings_s slot_wd = w_sav ? set_reg : file_image;

  ccs_slot_mem #(
    .SLOTS (SLOTS),
    .W     (ccs_pkg::SET_W)
  ) u_slots (
    .mclk  (mclk),
    .rstn  (rstn),
    .we    (slot_we),
    .widx  (slot_wi),
    .wdata (slot_wd),
    .ridx  (arg_slot),
    .rdata (slot_rdata)
  );

  // ---------------------------------------------------------------------
  // settings image and presets
  // ---------------------------------------------------------------------
  wire [7:0] path_arg = cmd.wdata[15:8];

  always_comb begin
    set_next = set_reg;
    if (w_fact) begin
      set_next.path  = {ccs_pkg::NPATH{ccs_pkg::PATH_DEF}};
      set_next.dev   = ccs_pkg::DEV_DEF;
      set_next.setup = ccs_pkg::SETUP_DEF;
    end else if (w_rst) begin
      set_next.path  = {ccs_pkg::NPATH{ccs_pkg::PATH_DEF}};
      set_next.dev   = ccs_pkg::DEV_DEF;
    end else if (w_devp) begin
      set_next.dev   = ccs_pkg::DEV_DEF;
    end else if (w_pathp) begin
      for (int p = 0; p < ccs_pkg::NPATH; p++) begin
        if (path_arg == p[7:0]) set_next.path[p] = ccs_pkg::PATH_DEF;
      end
    end else if (w_rcl) begin
      set_next = slot_rdata;
    end else if (w_spath) begin
      for (int p = 0; p < ccs_pkg::NPATH; p++) begin
        if (path_arg == p[7:0]) set_next.path[p] = cmd.wdata[7:0];
      end
    end else if (w_sdev) begin
      set_next.dev = cmd.wdata[ccs_pkg::DEV_W-1:0];
    end else if (w_ssup) begin
      set_next.setup = cmd.wdata[ccs_pkg::SETUP_W-1:0];
    end else if (w_sprot) begin
      set_next.prot = cmd.wdata[ccs_pkg::PROT_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      set_reg <= {{ccs_pkg::NPATH{ccs_pkg::PATH_DEF}}, ccs_pkg::DEV_DEF,
                  ccs_pkg::SETUP_DEF, ccs_pkg::PROT_DEF};
    end else begin
      set_reg <= set_next;
    end
  end

  // ---------------------------------------------------------------------
  // option table
  // ---------------------------------------------------------------------
  wire [15:0] opt_word;
  wire [15:0] opt_list [OPT_N];

  for (genvar o = 0; o < OPT_N; o++) begin : g_opt
    assign opt_list[o] = opt_present[o] ? OPT_CODE[o*16 +: 16] : 16'h0000;
  end

  assign opt_word = (oidx_reg < OPT_N) ? opt_list[oidx_reg] : 16'h0000;

  always_ff @(posedge mclk) begin
    if (!rstn) oidx_reg <= '0;
    else if (w_oidx) oidx_reg <= cmd.wdata[OI_W-1:0];
  end

  // ---------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------
  always_comb begin
    rdata_next = '0;
    if (!cmd.rd) rdata_next = '0;
    else if (hit(cmd.addr, ccs_pkg::A_EVENT_ENABLE)) rdata_next = {8'h00, ese_reg};
    else if (hit(cmd.addr, ccs_pkg::A_EVENT_STATUS)) rdata_next = {8'h00, esr_reg};
    else if (hit(cmd.addr, ccs_pkg::A_INDIV_STATUS)) rdata_next = {15'h0000, ist};
    else if (hit(cmd.addr, ccs_pkg::A_OPTION_DATA))  rdata_next = opt_word;
    else if (hit(cmd.addr, ccs_pkg::A_PPOLL_ENABLE)) rdata_next = {8'h00, pre_reg};
    else if (hit(cmd.addr, ccs_pkg::A_POWER_CLEAR))  rdata_next = {15'h0000, psc_reg};
    else if (hit(cmd.addr, ccs_pkg::A_SRQ_ENABLE))   rdata_next = {8'h00, sre_reg};
    else if (hit(cmd.addr, ccs_pkg::A_STATUS_BYTE))  rdata_next = {8'h00, stb};
    else if (hit(cmd.addr, ccs_pkg::A_OUTPUT_BUF))   rdata_next = obuf_reg;
    else if (hit(cmd.addr, ccs_pkg::A_SET_DEVICE))   rdata_next = {8'h00, set_reg.dev};
    else if (hit(cmd.addr, ccs_pkg::A_SET_SETUP))    rdata_next = {12'h000, set_reg.setup};
    else if (hit(cmd.addr, ccs_pkg::A_SET_PROTECT))  rdata_next = {12'h000, set_reg.prot};
  end

  // ---------------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_o     <= '0;
      tst_start_o <= 1'b0;
      trig_o      <= 1'b0;
      clr_event_o <= 1'b0;
      hold_o      <= 1'b0;
      srq_o       <= 1'b0;
      ist_o       <= 1'b0;
      recall_o    <= 1'b0;
    end else begin
      rdata_o     <= rdata_next;
      tst_start_o <= w_tst && (state_reg == CCS_IDLE);
      trig_o      <= w_trg;
      clr_event_o <= w_cls;
      hold_o      <= (state_next == CCS_WAIT);
      srq_o       <= rqs;
      ist_o       <= ist;
      recall_o    <= w_rcl;
    end
  end

  assign settings_o = set_reg;

endmodule : ccs_common

// ### verif/ccs_props.sv
// checker: port timing of the command interpreter
// assumes one clock domain, bound into ccs_common
`timescale 1ns/100ps
module ccs_props (
  input wire logic                   mclk,        // clock
  input wire logic                   rstn,        // reset
  input wire ccs_pkg::ccs_cmd_s      cmd,         // commands
  input wire logic [15:0]            rdata_o,     // read data
  input wire ccs_pkg::ccs_settings_s settings_o,  // settings
  input wire logic                   exec_busy,   // busy
  input wire logic                   trig_o,      // trigger
  input wire logic                   clr_event_o, // clear
  input wire logic                   hold_o,      // stall
  input wire logic                   recall_o     // recall
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic [4:0] a = cmd.addr;
  wire logic       w = cmd.wr;
  AST_CLS: assert property (w && a == 5'h00 |=> clr_event_o) else $error("clear");
  AST_ESR: assert property (cmd.rd && a == 5'h02 |=> rdata_o[15:8] == 8'h00) else $error("esr");
  AST_SRE: assert property (cmd.rd && a == 5'h0D |=> !rdata_o[6]) else $error("sre");
  AST_RCL: assert property (w && a == 5'h0A |=> recall_o) else $error("recall");
  AST_RST: assert property (w && a == 5'h0B |=> settings_o.dev == 8'h00 && $stable(settings_o.setup)) else $error("rst");
  AST_TRG: assert property (w && a == 5'h0F |=> trig_o) else $error("trigger");
  AST_WAI: assert property (w && a == 5'h11 && exec_busy ##1 exec_busy |-> hold_o) else $error("hold");
  AST_DEV: assert property (w && a == 5'h12 |=> settings_o.dev == 8'h00 && $stable(settings_o.path)) else $error("dev");
  cover property (hold_o);
  cover property (recall_o);
  cover property (trig_o);
endmodule : ccs_props
bind ccs_common ccs_props u_props (.*);

// ### verif/ccs_tst_model.sv
// far-side self-test engine: answers each start after a delay
// assumes one start per run; the code is junk outside the answer
`timescale 1ns/100ps
module ccs_tst_model #(parameter int DLY = 1) (
  input  wire logic        mclk,        // clock
  input  wire logic        tst_start_o, // start pulse
  output logic             tst_done,    // end pulse
  output logic      [15:0] tst_code     // result
);
  int n = 0;
  initial {tst_done, tst_code} = 17'h00000;
  always @(posedge mclk) begin
    n        <= tst_start_o ? DLY : n - (n > 0);
    tst_done <= n == 1;
    tst_code <= n == 1 ? 16'h0007 : ~tst_code;
  end
endmodule : ccs_tst_model

// ### verif/testbench.sv
// bench: table of accesses {read, addr, data}; addr 1F drives side inputs or checks settings, 1E checks paths
// assumes the self-test model answers within the nops that follow a start
`timescale 1ns/100ps
module testbench;
  logic        mclk = 1'h0, rstn = 1'h0, power_on = 1'h0, exec_busy = 1'h0, ques_sum = 1'h0;
  logic        settled = 1'h1, file_load = 1'h0, tst_done, tst_start_o, trig_o, clr_event_o, hold_o, srq_o, ist_o;
  logic        recall_o;
  logic [7:0]  esr_set = 8'h00;
  logic [15:0] rdata_o, tst_code;
  ccs_pkg::ccs_cmd_s      cmd = '0;
  ccs_pkg::ccs_settings_s settings_o;
  int          n_errors = 0, comparisons = 0, i;
  logic [21:0] ops [$] = {22'h0100FF, 22'h2100FF, 22'h080008, 22'h280008, 22'h0D00FF, 22'h2D00BF,
    22'h090000, 22'h290000, 22'h1F0004, 22'h1F0000, 22'h2100FF, 22'h1F0400, 22'h1F0000, 22'h220080,
    22'h220000, 22'h1F0002, 22'h050000, 22'h2E0058, 22'h230001, 22'h000000, 22'h360000, 22'h050000,
    22'h360001, 22'h1F0001, 22'h040000, 22'h110000, 22'h1F0000, 22'h220001, 22'h1F1000, 22'h040000,
    22'h220000, 22'h1F0000, 22'h220001, 22'h18003C, 22'h190005,
    22'h0C0002, 22'h0B0000, 22'h3F0050, 22'h0A0002, 22'h3F3C50, 22'h120000, 22'h3F0050, 22'h1A0003,
    22'h150000, 22'h3F0003, 22'h170112, 22'h170034, 22'h3E1234, 22'h130100, 22'h3E0034, 22'h140000,
    22'h3E0000, 22'h060001, 22'h270000, 22'h060002, 22'h270003, 22'h1F0800, 22'h1F0000, 22'h0A0000,
    22'h3FA5C0, 22'h0F0000, 22'h100000, 22'h1F0000, 22'h1F0000, 22'h1F0000, 22'h360007, 22'h090001,
    22'h1F0004, 22'h1F0000, 22'h210000, 22'h2D0000, 22'h3D0000};
  ccs_common DUT (.*, .err_avail(1'h0), .oper_sum(1'h0), .opt_present(4'h5), .file_slot(3'h0),
    .file_image(32'h0000A5C0));
  ccs_tst_model u_tst (.*);
  initial forever #10 mclk = ~mclk;
  task chk(string s, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task summarize;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task acc(logic [21:0] op);
    if (op[20:16] == 5'h1F && op[21]) @(negedge mclk) chk("settings",
      {settings_o.dev, settings_o.setup, settings_o.prot}, op[15:0]);
    else if (op[20:16] == 5'h1E && op[21]) @(negedge mclk) chk("paths", settings_o.path, op[15:0]);
    else if (op[20:16] == 5'h1F) begin
      @(posedge mclk) {file_load, esr_set, power_on, ques_sum, exec_busy} <= op[11:0];
      settled <= !op[12];
    end else begin
      // later commands must not be issued while the block stalls them;
      // hold is looked at off the edge that launches it
      @(negedge mclk);
      for (i = 0; i < 50 && hold_o !== 1'h0; i++) @(negedge mclk);
      chk("hold", 16'(i < 50), 16'h0001);
      @(posedge mclk) cmd <= '{op[20:16], op[15:0], !op[21], op[21]};
      @(posedge mclk) cmd <= '0;
      if (op[21]) @(negedge mclk) begin
        chk($sformatf("addr %h", op[20:16]), rdata_o, op[15:0]);
        if (op[20:16] == 5'h03) chk("ist", 16'(ist_o), op[15:0]);
        if (op[20:16] == 5'h0E) chk("srq", 16'(srq_o), 16'(op[6]));
      end
    end
  endtask : acc
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'h1;
    // a stalled hold ends the table early; the mismatch is already counted
    foreach (ops[k]) if (i < 50) acc(ops[k]);
    $display("test command table done");
    summarize();
  end
endmodule : testbench
